// [hw/lpw_wake_ctrl.v]
// Behaviour
// R1: Serial peripheral runs in wait; its enabled requests end wait.
// R2: Serial peripheral halts in stop; reset exit aborts and resets it.
// R3: Both timers count in wait; enabled timer requests end wait.
// R4: Timers halt in stop keeping state; resume after external interrupt.
// R5: Wakeup timer runs in wait; its register is blocked from CPU.
// R6: Wakeup timer runs in stop only with oscillator kept; register blocked.
// R7: Reset pin, watchdog, brownout reset device, end wait, fetch reset vector.
// R8: External pin falling edge ends wait or stop, fetches its vector.
// R9: Break interrupt ends wait or stop, fetches break vector.
// R10: Clock generator request ends wait, fetches its vector.
// R11: Keypad request, or keypad pin fall in stop, ends state, keypad vector.
// R12: Timer one overflow, channel 1, channel 0 fetch distinct vectors.
// R13: Timer two overflow, channel 1, channel 0 fetch distinct vectors.
// R14: Serial peripheral transmit and receive fetch distinct vectors.
// R15: Async serial transmit, receive, error fetch distinct vectors.
// R16: Converter complete ends wait, fetches its vector.
// R17: Wakeup timer rollover ends wait or stop, fetches its vector.
// R18: Stop ends only on listed reset, pin, brownout, break, wakeup events.
// R19: Stop exit holds system clocks off 4096 reference clock cycles.
// R20: Short-recovery option shrinks hold-off to 32 cycles.
// R21: Software should keep short recovery cleared with an external crystal.
// R22: In wait CPU clock is gated, bus clock keeps running.
// R23: In stop CPU clock gated; bus clock stops unless oscillator kept.
// R24: Vector high byte from lower address, low byte from higher address.
// R25: Wakeup timer register access blocked in wait or stop, then restored.
`include "lpw_regs.vh"
module lpw_wake_ctrl (
	input  wire        clk_in,
	input  wire        resetn_in,
	// Mode entry from the CPU core, one-cycle pulses
	input  wire        wait_enter_in,
	input  wire        stop_enter_in,
	// Option bits
	input  wire        oscillator_kept_in_stop_in,
	input  wire        short_recovery_select_in,
	// Asynchronous pins, active low
	input  wire        reset_pin_n_in,
	input  wire        ext_irq_pin_n_in,
	input  wire [7:0]  keypad_pins_n_in,
	// Reset sources from on-chip logic
	input  wire        watchdog_timeout_in,
	input  wire        brownout_in,
	// Enabled interrupt requests, levels from on-chip logic
	input  wire        break_req_in,
	input  wire        clkgen_req_in,
	input  wire        keypad_req_in,
	input  wire        t1_ovf_req_in,
	input  wire        t1_ch1_req_in,
	input  wire        t1_ch0_req_in,
	input  wire        t2_ovf_req_in,
	input  wire        t2_ch1_req_in,
	input  wire        t2_ch0_req_in,
	input  wire        ssp_tx_req_in,
	input  wire        ssp_rx_req_in,
	input  wire        asu_tx_req_in,
	input  wire        asu_rx_req_in,
	input  wire        asu_err_req_in,
	input  wire        adc_req_in,
	input  wire        wake_tmr_rollover_in,
	// Vector fetch handshake from the CPU core
	input  wire        vec_ack_in,
	// Clock gates and peripheral run enables
	output wire        cpu_clk_en_out,
	output wire        bus_clk_en_out,
	output wire        ssp_run_out,
	output wire        ssp_abort_out,
	output wire        timer_run_out,
	output wire        wake_tmr_run_out,
	output wire        wake_tmr_access_en_out,
	output wire        device_reset_out,
	output wire        in_wait_out,
	output wire        in_stop_out,
	output wire        in_recovery_out,
	// Vector fetch request toward the CPU core
	output wire        vec_valid_out,
	output reg  [15:0] vec_addr_hi_out,
	output reg  [15:0] vec_addr_lo_out
);
	localparam [4:0] ST_RUN     = 5'b00001;
	localparam [4:0] ST_WAIT    = 5'b00010;
	localparam [4:0] ST_STOP    = 5'b00100;
	localparam [4:0] ST_RECOVER = 5'b01000;
	localparam [4:0] ST_VECTOR  = 5'b10000;

	wire        rst_pin_n_s;
	wire        ext_pin_n_s;
	wire [7:0]  kbd_n_s;
	wire        ext_fall;
	wire [7:0]  kbd_fall;

	reg  [4:0]  state_q;
	reg  [4:0]  state_d;
	reg  [11:0] rec_cnt_q;
	reg  [11:0] rec_cnt_d;
	reg         from_reset_q;
	reg         from_reset_d;
	reg         vec_latched_q;
	reg  [15:0] vec_sel;
	reg  [15:0] vec_hold_q;
	reg  [15:0] vec_hold_d;
	wire        any_reset;
	wire        stop_wake;
	wire        wait_wake;
	wire        kbd_pin_fall;

	// Pins pass two flops before any logic reads them
	lpw_sync2 #(.W(10)) u_sync (
		.clk_in    (clk_in),
		.resetn_in (resetn_in),
		.d_in      ({reset_pin_n_in, ext_irq_pin_n_in, keypad_pins_n_in}),
		.q_out     ({rst_pin_n_s, ext_pin_n_s, kbd_n_s})
	);

	// Edge detect on synchronised external and keypad pins
	lpw_fall_det #(.W(9)) u_fall (
		.clk_in    (clk_in),
		.resetn_in (resetn_in),
		.lvl_in    ({ext_pin_n_s, kbd_n_s}),
		.fall_out  ({ext_fall, kbd_fall})
	);

	// R7: reset sources
	assign any_reset    = ~rst_pin_n_s | watchdog_timeout_in | brownout_in;
	assign kbd_pin_fall = |kbd_fall;

	// R18: only listed events may end stop; watchdog is unclocked in stop
	assign stop_wake = ~rst_pin_n_s | brownout_in | ext_fall | kbd_pin_fall | break_req_in
		| (wake_tmr_rollover_in & oscillator_kept_in_stop_in);

	// R1: R3: R10: R16: any enabled request ends wait
	assign wait_wake = any_reset | ext_fall | break_req_in | clkgen_req_in | keypad_req_in
		| t1_ovf_req_in | t1_ch1_req_in | t1_ch0_req_in
		| t2_ovf_req_in | t2_ch1_req_in | t2_ch0_req_in
		| ssp_tx_req_in | ssp_rx_req_in
		| asu_tx_req_in | asu_rx_req_in | asu_err_req_in
		| adc_req_in | wake_tmr_rollover_in;

	// Priority vector select; resets first, then fixed order of sources
	always @* begin
		vec_sel = `LPW_VEC_NONE;
		// R7: reset vector
		if (any_reset)
			vec_sel = `LPW_VEC_RESET;
		// R8: external pin vector
		else if (ext_fall)
			vec_sel = `LPW_VEC_EXT_PIN;
		// R9: break vector
		else if (break_req_in)
			vec_sel = `LPW_VEC_BREAK;
		// R10: clock generator vector
		else if (clkgen_req_in && state_q != ST_STOP)
			vec_sel = `LPW_VEC_CLKGEN;
		// R12: timer one vectors
		else if (t1_ch0_req_in && state_q != ST_STOP)
			vec_sel = `LPW_VEC_T1_CH0;
		else if (t1_ch1_req_in && state_q != ST_STOP)
			vec_sel = `LPW_VEC_T1_CH1;
		else if (t1_ovf_req_in && state_q != ST_STOP)
			vec_sel = `LPW_VEC_T1_OVF;
		// R13: timer two vectors
		else if (t2_ch0_req_in && state_q != ST_STOP)
			vec_sel = `LPW_VEC_T2_CH0;
		else if (t2_ch1_req_in && state_q != ST_STOP)
			vec_sel = `LPW_VEC_T2_CH1;
		else if (t2_ovf_req_in && state_q != ST_STOP)
			vec_sel = `LPW_VEC_T2_OVF;
		// R14: serial peripheral vectors
		else if (ssp_rx_req_in && state_q != ST_STOP)
			vec_sel = `LPW_VEC_SSP_RX;
		else if (ssp_tx_req_in && state_q != ST_STOP)
			vec_sel = `LPW_VEC_SSP_TX;
		// R15: async serial vectors
		else if (asu_err_req_in && state_q != ST_STOP)
			vec_sel = `LPW_VEC_ASU_ERR;
		else if (asu_rx_req_in && state_q != ST_STOP)
			vec_sel = `LPW_VEC_ASU_RX;
		else if (asu_tx_req_in && state_q != ST_STOP)
			vec_sel = `LPW_VEC_ASU_TX;
		// R11: keypad request outside stop, or pin edge in any state
		else if (kbd_pin_fall || (keypad_req_in && state_q != ST_STOP))
			vec_sel = `LPW_VEC_KEYPAD;
		// R16: converter vector
		else if (adc_req_in && state_q != ST_STOP)
			vec_sel = `LPW_VEC_ADC;
		// R17: wakeup timer vector
		else if (wake_tmr_rollover_in)
			vec_sel = `LPW_VEC_WAKE_TMR;
	end

	// Mode sequencer
	always @* begin
		state_d      = state_q;
		rec_cnt_d    = rec_cnt_q;
		from_reset_d = from_reset_q;
		vec_hold_d   = vec_hold_q;
		case (state_q)
			ST_RUN: begin
				if (stop_enter_in)
					state_d = ST_STOP;
				else if (wait_enter_in)
					state_d = ST_WAIT;
			end
			ST_WAIT: begin
				if (wait_wake) begin
					state_d      = ST_VECTOR;
					vec_hold_d   = vec_sel;
					from_reset_d = any_reset;
				end
			end
			ST_STOP: begin
				if (stop_wake) begin
					state_d      = ST_RECOVER;
					vec_hold_d   = vec_sel;
					from_reset_d = any_reset;
					// R19: R20: load hold-off count
					rec_cnt_d    = short_recovery_select_in ? `LPW_RECOVERY_SHORT : `LPW_RECOVERY_FULL;
				end
			end
			ST_RECOVER: begin
				// R19: count down hold-off
				if (rec_cnt_q == `LPW_CNT_ZERO)
					state_d = ST_VECTOR;
				else
					rec_cnt_d = rec_cnt_q - 12'h001;
			end
			ST_VECTOR: begin
				if (vec_ack_in) begin
					state_d      = ST_RUN;
					from_reset_d = 1'b0;
				end
			end
			default: state_d = ST_RUN;
		endcase
	end

	// State and hold registers
	always @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state_q       <= ST_RUN;
			rec_cnt_q     <= `LPW_CNT_ZERO;
			from_reset_q  <= 1'b0;
			vec_hold_q    <= `LPW_VEC_NONE;
			vec_latched_q <= 1'b0;
		end else begin
			state_q       <= state_d;
			rec_cnt_q     <= rec_cnt_d;
			from_reset_q  <= from_reset_d;
			vec_hold_q    <= vec_hold_d;
			vec_latched_q <= (state_d == ST_VECTOR);
		end
	end

	// R24: high byte from the even address, low byte from the next
	always @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			vec_addr_hi_out <= `LPW_VEC_NONE;
			vec_addr_lo_out <= `LPW_VEC_NONE;
		end else begin
			vec_addr_hi_out <= vec_hold_d;
			vec_addr_lo_out <= vec_hold_d + `LPW_VEC_LO_OFS;
		end
	end

	assign in_wait_out     = (state_q == ST_WAIT);
	assign in_stop_out     = (state_q == ST_STOP);
	assign in_recovery_out = (state_q == ST_RECOVER);
	assign vec_valid_out   = vec_latched_q;

	// R22: R23: CPU clock off in any low-power or recovery state
	assign cpu_clk_en_out = (state_q == ST_RUN) | (state_q == ST_VECTOR);
	// R23: R19: bus clock stops in stop unless oscillator kept, and in hold-off
	assign bus_clk_en_out = ~in_recovery_out & ~(in_stop_out & ~oscillator_kept_in_stop_in);

	// R1: R2: serial peripheral halts only in stop and hold-off
	assign ssp_run_out = ~in_stop_out & ~in_recovery_out;
	// R2: abort transfer when stop ends by reset
	assign ssp_abort_out = from_reset_q & (state_q == ST_RECOVER | state_q == ST_VECTOR);
	// R3: R4: timers count in wait, freeze in stop keeping state
	assign timer_run_out = ~in_stop_out & ~in_recovery_out;
	// R5: R6: wakeup timer runs in wait, in stop only with oscillator kept
	assign wake_tmr_run_out = ~in_recovery_out & (~in_stop_out | oscillator_kept_in_stop_in);
	// R25: R5: R6: register gated off while wait or stop lasts
	assign wake_tmr_access_en_out = ~in_wait_out & ~in_stop_out;
	// R7: device reset request
	assign device_reset_out = from_reset_q & (state_q == ST_VECTOR);
endmodule

// [hw/lpw_regs.vh]
`ifndef LPW_REGS_VH
`define LPW_REGS_VH
// Vector addresses (high byte at the even address, low byte at the next)
`define LPW_VEC_RESET      16'hFFFE
`define LPW_VEC_EXT_PIN    16'hFFFA
`define LPW_VEC_BREAK      16'hFFFC
`define LPW_VEC_CLKGEN     16'hFFF8
`define LPW_VEC_T1_OVF     16'hFFF2
`define LPW_VEC_T1_CH1     16'hFFF4
`define LPW_VEC_T1_CH0     16'hFFF6
`define LPW_VEC_T2_OVF     16'hFFEC
`define LPW_VEC_T2_CH1     16'hFFEE
`define LPW_VEC_T2_CH0     16'hFFF0
`define LPW_VEC_SSP_TX     16'hFFE8
`define LPW_VEC_SSP_RX     16'hFFEA
`define LPW_VEC_ASU_TX     16'hFFE2
`define LPW_VEC_ASU_RX     16'hFFE4
`define LPW_VEC_ASU_ERR    16'hFFE6
`define LPW_VEC_KEYPAD     16'hFFE0
`define LPW_VEC_ADC        16'hFFDE
`define LPW_VEC_WAKE_TMR   16'hFFDC
`define LPW_VEC_NONE       16'h0000
// Offset of the low byte within a vector pair
`define LPW_VEC_LO_OFS     16'h0001
// Stop recovery hold-off load values, one less than the hold-off in crystal reference clock cycles
`define LPW_RECOVERY_FULL  12'hFFF
`define LPW_RECOVERY_SHORT 12'h01F
`define LPW_CNT_ZERO       12'h000
// Number of wake sources in the request vector
`define LPW_NSRC           18
`endif

// [hw/lpw_sync2.v]
// Two-stage synchroniser for asynchronous active-low pin inputs, idle high
module lpw_sync2 #(
	parameter W = 1
) (
	input  wire         clk_in,
	input  wire         resetn_in,
	input  wire [W-1:0] d_in,
	output wire [W-1:0] q_out
);
	reg [W-1:0] meta_q;
	reg [W-1:0] sync_q;

	// First stage feeds only the second stage; reset to the idle high level
	// so release neither fakes a reset pin nor a falling edge downstream
	always @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			meta_q <= {W{1'b1}};
			sync_q <= {W{1'b1}};
		end else begin
			meta_q <= d_in;
			sync_q <= meta_q;
		end
	end

	assign q_out = sync_q;
endmodule

// [hw/lpw_fall_det.v]
// Falling-edge detector on an already synchronised level, idle high
module lpw_fall_det #(
	parameter W = 1
) (
	input  wire         clk_in,
	input  wire         resetn_in,
	input  wire [W-1:0] lvl_in,
	output wire [W-1:0] fall_out
);
	reg [W-1:0] prev_q;

	// Reset to high so a level still low at release reads as a falling edge
	always @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in)
			prev_q <= {W{1'b1}};
		else
			prev_q <= lvl_in;
	end

	assign fall_out = prev_q & ~lvl_in;
endmodule

// [dv/lpw_props.sv]
module lpw_props (
	input wire        clk_in,
	input wire        resetn_in,
	input wire        oscillator_kept_in_stop_in,
	input wire        short_recovery_select_in,
	input wire        adc_req_in,
	input wire        vec_ack_in,
	input wire        cpu_clk_en_out,
	input wire        bus_clk_en_out,
	input wire        ssp_run_out,
	input wire        timer_run_out,
	input wire        wake_tmr_run_out,
	input wire        wake_tmr_access_en_out,
	input wire        in_wait_out,
	input wire        in_stop_out,
	input wire        in_recovery_out,
	input wire        vec_valid_out,
	input wire [15:0] vec_addr_hi_out,
	input wire [15:0] vec_addr_lo_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [12:0] rec_q;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!resetn_in);
	// Hold-off length counter; too long for a repetition operator
	always @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rec_q <= 13'h0000;
		end else begin
			rec_q <= in_recovery_out ? rec_q + 13'h0001 : 13'h0000;
		end
	end
	a_wait_gate: assert property (in_wait_out |-> !cpu_clk_en_out && bus_clk_en_out && ssp_run_out
		&& timer_run_out && wake_tmr_run_out) else $error("wait gating wrong");
	a_stop_gate: assert property (in_stop_out && !in_recovery_out |-> !cpu_clk_en_out && !ssp_run_out
		&& !timer_run_out && bus_clk_en_out == oscillator_kept_in_stop_in
		&& wake_tmr_run_out == oscillator_kept_in_stop_in) else $error("stop gating wrong");
	a_access_block: assert property (in_wait_out || in_stop_out |-> !wake_tmr_access_en_out)
		else $error("timer register reachable");
	a_hold_gate: assert property (in_recovery_out |-> !cpu_clk_en_out && !bus_clk_en_out)
		else $error("clocks run in hold-off");
	a_hold_len: assert property ($fell(in_recovery_out) |->
		rec_q == (short_recovery_select_in ? 13'h0020 : 13'h1000)) else $error("hold-off length wrong");
	a_vec_pair: assert property (vec_valid_out |-> vec_addr_lo_out == vec_addr_hi_out + 16'h0001)
		else $error("vector pair wrong");
	a_vec_stand: assert property (vec_valid_out && !vec_ack_in |=> vec_valid_out && $stable(vec_addr_hi_out))
		else $error("vector dropped early");
	a_ack_release: assert property (vec_valid_out && vec_ack_in |=> !vec_valid_out)
		else $error("vector kept after ack");
	a_adc_wake: assert property (in_wait_out && adc_req_in |=> !in_wait_out ##1 vec_valid_out)
		else $error("wait not ended in time");
	c_hold_end: cover property ($fell(in_recovery_out));
	c_adc_wake: cover property (in_wait_out && adc_req_in);
	c_stop_tmr: cover property (in_stop_out && wake_tmr_run_out);
endmodule
bind lpw_wake_ctrl lpw_props u_props (.clk_in, .resetn_in, .oscillator_kept_in_stop_in, .short_recovery_select_in,
	.adc_req_in, .vec_ack_in, .cpu_clk_en_out, .bus_clk_en_out, .ssp_run_out, .timer_run_out, .wake_tmr_run_out,
	.wake_tmr_access_en_out, .in_wait_out, .in_stop_out, .in_recovery_out, .vec_valid_out, .vec_addr_hi_out,
	.vec_addr_lo_out);

// [dv/lpw_cpu_model.sv]
module lpw_cpu_model (
	input  wire         clk_in,
	input  wire         resetn_in,
	input  wire         vec_valid_in,
	input  wire  [15:0] vec_addr_hi_in,
	input  wire  [1:0]  dly_in,
	output logic        vec_ack_out,
	output logic [15:0] got_out,
	output logic [7:0]  got_n_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt_q;
	// Ack after a chosen wait; the count runs on so one vector is taken once
	always @(negedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			vec_ack_out <= 1'b0;
			cnt_q <= 4'h0;
			got_out <= 16'h0000;
			got_n_out <= 8'h00;
		end else begin
			vec_ack_out <= vec_valid_in && cnt_q == {2'b00, dly_in};
			cnt_q <= vec_valid_in ? cnt_q + 4'h1 : 4'h0;
			if (vec_valid_in && cnt_q == {2'b00, dly_in}) begin
				got_out <= vec_addr_hi_in;
				got_n_out <= got_n_out + 8'h01;
			end
		end
	end
endmodule

// [dv/tb_top.sv]
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_in, resetn_in, wait_enter_in, stop_enter_in, vec_ack_in;
	logic        oscillator_kept_in_stop_in, short_recovery_select_in;
	logic        cpu_clk_en_out, bus_clk_en_out, ssp_run_out, ssp_abort_out, timer_run_out;
	logic        wake_tmr_run_out, wake_tmr_access_en_out, device_reset_out;
	logic        in_wait_out, in_stop_out, in_recovery_out, vec_valid_out;
	logic [15:0] vec_addr_hi_out, got;
	logic [20:0] src;
	logic [7:0]  got_n;
	logic [1:0]  dly;
	int          fail_count, compares;
	logic [15:0] vec_tab [21] = '{16'hFFFC, 16'hFFF8, 16'hFFE0, 16'hFFF2, 16'hFFF4, 16'hFFF6, 16'hFFEC,
		16'hFFEE, 16'hFFF0, 16'hFFE8, 16'hFFEA, 16'hFFE2, 16'hFFE4, 16'hFFE6, 16'hFFDE, 16'hFFDC, 16'hFFFE,
		16'hFFFE, 16'hFFFA, 16'hFFFE, 16'hFFE0};
	lpw_wake_ctrl dut_u (
		.clk_in, .resetn_in, .wait_enter_in, .stop_enter_in, .oscillator_kept_in_stop_in,
		.short_recovery_select_in, .reset_pin_n_in(!src[19]), .ext_irq_pin_n_in(!src[18]),
		.keypad_pins_n_in({7'h7F, !src[20]}), .watchdog_timeout_in(src[16]), .brownout_in(src[17]),
		.break_req_in(src[0]), .clkgen_req_in(src[1]), .keypad_req_in(src[2]), .t1_ovf_req_in(src[3]),
		.t1_ch1_req_in(src[4]), .t1_ch0_req_in(src[5]), .t2_ovf_req_in(src[6]), .t2_ch1_req_in(src[7]),
		.t2_ch0_req_in(src[8]), .ssp_tx_req_in(src[9]), .ssp_rx_req_in(src[10]), .asu_tx_req_in(src[11]),
		.asu_rx_req_in(src[12]), .asu_err_req_in(src[13]), .adc_req_in(src[14]),
		.wake_tmr_rollover_in(src[15]), .vec_ack_in, .cpu_clk_en_out, .bus_clk_en_out, .ssp_run_out,
		.ssp_abort_out, .timer_run_out, .wake_tmr_run_out, .wake_tmr_access_en_out, .device_reset_out,
		.in_wait_out, .in_stop_out, .in_recovery_out, .vec_valid_out, .vec_addr_hi_out, .vec_addr_lo_out()
	);
	lpw_cpu_model cpu_u (.clk_in, .resetn_in, .vec_valid_in(vec_valid_out), .vec_addr_hi_in(vec_addr_hi_out),
		.dly_in(dly), .vec_ack_out(vec_ack_in), .got_out(got), .got_n_out(got_n));
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wrap_up;
		if (fail_count == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// One low-power entry, one wake source, then the vector and gating are judged
	task automatic wake(input int s, input bit stp, input bit sh, input bit os);
		logic [7:0] g;
		logic [1:0] rs;
		logic       r;
		int         n;
		g = got_n;
		rs = 2'b00;
		n = 0;
		r = (s == 16 || s == 17 || s == 19);
		dly = s[1:0];
		short_recovery_select_in = sh;
		oscillator_kept_in_stop_in = os;
		if (stp) stop_enter_in = 1'b1;
		else wait_enter_in = 1'b1;
		@(negedge clk_in);
		wait_enter_in = 1'b0;
		stop_enter_in = 1'b0;
		@(negedge clk_in);
		chk("gates", {in_wait_out, in_stop_out, cpu_clk_en_out, bus_clk_en_out, ssp_run_out, timer_run_out,
			wake_tmr_run_out, wake_tmr_access_en_out}, {!stp, stp, 1'b0, stp ? os : 1'b1, !stp, !stp,
			stp ? os : 1'b1, 1'b0});
		if (stp) begin
			// Clock generator, watchdog, timer and an idle wakeup timer must not end stop
			src[1] = 1'b1;
			src[16] = 1'b1;
			src[3] = 1'b1;
			src[15] = !os;
			repeat (20) @(negedge clk_in);
			src = '0;
			chk("stop_held", in_stop_out, 1'b1);
		end
		src[s] = 1'b1;
		for (int k = 0; k < 9000 && got_n == g; k++) begin
			@(negedge clk_in);
			n += in_recovery_out;
			if (vec_valid_out) rs = {device_reset_out, ssp_abort_out};
		end
		src = '0;
		chk("acked", {8'h00, got_n - g}, 16'h0001);
		chk("vector", got, vec_tab[s]);
		chk("holdoff", n[15:0], stp ? (sh ? 16'h0020 : 16'h1000) : 16'h0000);
		chk("reset_exit", {rs[1], rs[0] & stp}, {r, r & stp});
		repeat (2) @(negedge clk_in);
		chk("access", {in_wait_out, in_stop_out, wake_tmr_access_en_out, timer_run_out, ssp_run_out,
			cpu_clk_en_out, bus_clk_en_out, wake_tmr_run_out}, 8'h3F);
	endtask
	// Free-running bench clock at 125 MHz
	initial begin
		clk_in = 1'b0;
		forever #4 clk_in = ~clk_in;
	end
	// Cut a hang short well past the expected run time
	initial begin
		#500us;
		fail_count++;
		wrap_up;
	end
	// Main sequence: every wait wake source, then stop exits
	initial begin
		{resetn_in, wait_enter_in, stop_enter_in, oscillator_kept_in_stop_in, short_recovery_select_in} = '0;
		src = '0;
		dly = 2'b00;
		repeat (10) @(negedge clk_in);
		resetn_in = 1'b1;
		repeat (4) @(negedge clk_in);
		for (int i = 0; i < 20; i++) wake(i, 1'b0, 1'b0, 1'b0);
		// full hold-off kept for the crystal case
		wake(18, 1'b1, 1'b0, 1'b0);
		wake(20, 1'b1, 1'b1, 1'b0);
		wake(0, 1'b1, 1'b1, 1'b1);
		wake(17, 1'b1, 1'b1, 1'b0);
		wake(15, 1'b1, 1'b1, 1'b1);
		wake(19, 1'b1, 1'b0, 1'b1);
		wrap_up;
	end
endmodule
